// file: hdl/csp_defs.vh
/*
 * Constants for the core special function registers and I/O ports:
 * data memory offsets, status bit positions, reset values, table widths.
 * Assumes it is included once per compile unit by its bare name.
 */
`ifndef CSP_DEFS_VH
`define CSP_DEFS_VH

// ****************************************
// data memory offsets
// ****************************************
`define CSP_A_PCL 8'h02
`define CSP_A_TBLP 8'h07
`define CSP_A_TABLE_HIGH_BYTE_LATCH 8'h08
`define CSP_A_WATCHDOG_PRESCALE_SELECT 8'h09
`define CSP_A_STATUS 8'h0A
`define CSP_A_INTERRUPT_CONTROL_REG 8'h0B
`define CSP_A_TABLE_POINTER_UPPER 8'h0D
`define CSP_A_PORT_BASE 8'h12

// ****************************************
// status and interrupt control bit positions
// ****************************************
`define CSP_ST_C 0
`define CSP_ST_AC 1
`define CSP_ST_Z 2
`define CSP_ST_OV 3
`define CSP_ST_PDF 4
`define CSP_ST_TO 5
`define CSP_IC_EMI 0
`define CSP_IC_EEI 1
`define CSP_IC_ETI 2

// ****************************************
// reset values and widths
// ****************************************
`define CSP_PORT_RST 8'hFF
`define CSP_NUM_PORTS 3
`define CSP_PC_W 12
`define CSP_ROM_W 15
`define CSP_TABLE_POINTER_UPPER_W 4
`define CSP_WDT_DIV_MAX 7'h7F

// ****************************************
// flag unit modes
// ****************************************
`define CSP_FM_ADD 2'h0
`define CSP_FM_SUB 2'h1
`define CSP_FM_LOGIC 2'h2
`define CSP_FM_ROT 2'h3

`endif

// file: hdl/csp_flags.v
/*
 * Arithmetic flag calculation for one ALU operation (combinational).
 * Assumes the core supplies operands, carry in and the operation kind.
 */
`default_nettype none
`include "csp_defs.vh"

module csp_flags (
  input wire [7:0] op_a,
  input wire [7:0] op_b,
  input wire cin,
  input wire [1:0] mode,
  input wire rot_left,
  input wire [7:0] logic_res,
  output reg c_new,
  output reg ac_new,
  output reg z_new,
  output reg ov_new
);

  wire [7:0] bb;
  wire [8:0] sum9;
  wire [4:0] lo5;
  wire [7:0] lo8;

  // subtraction as a + ~b + cin, so carry out means no borrow
  assign bb = (mode == `CSP_FM_SUB) ? ~op_b : op_b;
  assign sum9 = {1'b0, op_a} + {1'b0, bb} + {8'h00, cin};
  assign lo5 = {1'b0, op_a[3:0]} + {1'b0, bb[3:0]} + {4'h0, cin};
  assign lo8 = {1'b0, op_a[6:0]} + {1'b0, bb[6:0]} + {7'h00, cin};

  always @* begin
    c_new = sum9[8];
    ac_new = lo5[4];
    ov_new = lo8[7] ^ sum9[8];
    z_new = (sum9[7:0] == 8'h00);
    case (mode)
      `CSP_FM_ADD, `CSP_FM_SUB: begin
        z_new = (sum9[7:0] == 8'h00);
      end
      `CSP_FM_LOGIC: begin
        z_new = (logic_res == 8'h00);
      end
      `CSP_FM_ROT: begin
        c_new = rot_left ? op_a[7] : op_a[0];
      end
      default: begin
        z_new = 1'b0;
      end
    endcase
  end

endmodule
`default_nettype wire

// file: hdl/csp_port.v
/*
 * One 8-bit I/O port: output latch, direction, pull-high and wake-up edges.
 * Assumes pin levels are synchronous to clk_sys.
 */
`default_nettype none
`include "csp_defs.vh"

module csp_port (
  input wire clk_sys,
  input wire rst_n,
  input wire clk_en,
  input wire [7:0] wr_data,
  input wire wr_dat,
  input wire wr_dir,
  input wire [7:0] pin_in,
  input wire [7:0] pu_opt,
  input wire [7:0] wake_mask,
  output reg [7:0] dat_ff,
  output reg [7:0] dir_ff,
  output reg [7:0] pin_oe_ff,
  output reg [7:0] pullup_ff,
  output wire [7:0] rd_val,
  output wire wake_ev
);

  reg [7:0] pin_prev_ff;

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      dat_ff <= `CSP_PORT_RST;
      dir_ff <= `CSP_PORT_RST;
      pin_oe_ff <= 8'h00;
      pullup_ff <= 8'h00;
      // seed with the live level so no false wake edge follows reset
      pin_prev_ff <= pin_in;
    end else if (clk_en) begin
      if (wr_dat) begin
        dat_ff <= wr_data;
      end
      if (wr_dir) begin
        dir_ff <= wr_data;
        pin_oe_ff <= ~wr_data;
      end
      pullup_ff <= pu_opt & (wr_dir ? wr_data : dir_ff);
      pin_prev_ff <= pin_in;
    end
  end

  // inputs read the live pin, outputs read back the latch
  assign rd_val = (dir_ff & pin_in) | (~dir_ff & dat_ff);
  // either edge on a wake-enabled pin
  assign wake_ev = |((pin_in ^ pin_prev_ff) & wake_mask);

endmodule
`default_nettype wire

// file: hdl/csp_sfr.v
/*
 * Special function registers and I/O ports of the 8-bit core.
 * Holds the program counter low byte, table read, status, interrupt
 * control, watchdog prescale, and three I/O ports with wake-up.
 * Assumes the core drives one data memory access per cycle on sfr_*,
 * pulses its instruction events for one cycle and answers table reads.
 */
`default_nettype none
`include "csp_defs.vh"

module csp_sfr (
  input wire clk_sys,
  input wire rst_n,
  input wire clk_en,
  input wire [7:0] sfr_addr,
  input wire sfr_wr,
  input wire [7:0] sfr_wdata,
  input wire sfr_rd,
  output reg [7:0] sfr_rdata_ff,
  input wire [11:0] pc_cur,
  output reg jump_ff,
  output reg [11:0] jump_addr_ff,
  output reg dummy_cycle_ff,
  input wire tab_rd,
  input wire [7:0] tab_dst,
  input wire opt_table_pointer_upper_en,
  output reg rom_req_ff,
  output reg [11:0] rom_addr_ff,
  input wire rom_valid,
  input wire [14:0] rom_data,
  output reg tab_lo_wr_ff,
  output reg [7:0] tab_lo_addr_ff,
  output reg [7:0] tab_lo_data_ff,
  input wire alu_upd_c,
  input wire alu_upd_acov,
  input wire alu_upd_z,
  input wire [1:0] alu_mode,
  input wire alu_rot_left,
  input wire [7:0] alu_op_a,
  input wire [7:0] alu_op_b,
  input wire alu_cin,
  input wire [7:0] alu_logic_res,
  input wire halt_instr,
  input wire watchdog_clear_instr,
  input wire int_entry,
  input wire return_from_interrupt,
  input wire wdt_src_tick,
  input wire wdt_overflow,
  output reg wdt_tick_ff,
  output reg wdt_reset_req_ff,
  output reg clk_stop_ff,
  output reg wake_ff,
  output reg master_interrupt_enable_ff,
  output reg ext_int_en_ff,
  output reg timer_int_en_ff,
  output reg ext_int_req_ff,
  output reg timer_event_input_ff,
  input wire [23:0] pin_in,
  output wire [23:0] pin_out,
  output wire [23:0] pin_oe,
  output wire [23:0] pin_pullup,
  input wire [7:0] pu_opt_a,
  input wire [3:0] pu_grp_bc,
  input wire [23:0] wake_mask
);

  // ****************************************
  // decode helpers
  // ****************************************
  function hit;
    input [7:0] addr;
    input [7:0] base;
    begin
      hit = (addr == base);
    end
  endfunction

  // nibble options widen to one enable per pin
  function [7:0] grp_expand;
    input [1:0] grp;
    begin
      grp_expand = {{4{grp[1]}}, {4{grp[0]}}};
    end
  endfunction

  // ****************************************
  // state
  // ****************************************
  reg [7:0] tblp_ff, tab_dst_ff, rd_mux;
  reg [6:0] table_high_byte_latch_ff, wdt_cnt_ff, wdt_lim;
  reg [3:0] table_pointer_upper_ff;
  reg [5:0] status_ff;
  reg [2:0] watchdog_prescale_select_ff;
  reg pc2_prev_ff;
  wire [23:0] port_dat, port_dir, port_rd;
  wire [2:0] port_wake;
  wire [23:0] pu_opt;
  wire f_c, f_ac, f_z, f_ov;
  wire st_wr;

  assign pu_opt = {grp_expand(pu_grp_bc[3:2]), grp_expand(pu_grp_bc[1:0]), pu_opt_a};
  assign st_wr = sfr_wr && hit(sfr_addr, `CSP_A_STATUS);

  // ****************************************
  // flag unit and ports
  // ****************************************
  csp_flags u_flags (
    .op_a(alu_op_a),
    .op_b(alu_op_b),
    .cin(alu_cin),
    .mode(alu_mode),
    .rot_left(alu_rot_left),
    .logic_res(alu_logic_res),
    .c_new(f_c),
    .ac_new(f_ac),
    .z_new(f_z),
    .ov_new(f_ov)
  );

  genvar gi;
  generate
    for (gi = 0; gi < `CSP_NUM_PORTS; gi = gi + 1) begin : g_port
      localparam integer dat_ofs = 2 * gi;
      localparam [7:0] dat_addr = `CSP_A_PORT_BASE + dat_ofs[7:0];
      localparam [7:0] dir_addr = dat_addr + 8'h01;
      csp_port u_port (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .wr_data(sfr_wdata),
        .wr_dat(sfr_wr && hit(sfr_addr, dat_addr)),
        .wr_dir(sfr_wr && hit(sfr_addr, dir_addr)),
        .pin_in(pin_in[8*gi+7:8*gi]),
        .pu_opt(pu_opt[8*gi+7:8*gi]),
        .wake_mask(wake_mask[8*gi+7:8*gi]),
        .dat_ff(port_dat[8*gi+7:8*gi]),
        .dir_ff(port_dir[8*gi+7:8*gi]),
        .pin_oe_ff(pin_oe[8*gi+7:8*gi]),
        .pullup_ff(pin_pullup[8*gi+7:8*gi]),
        .rd_val(port_rd[8*gi+7:8*gi]),
        .wake_ev(port_wake[gi])
      );
    end
  endgenerate

  assign pin_out = port_dat;

  // ****************************************
  // read mux
  // ****************************************
  always @* begin
    rd_mux = 8'h00;
    case (sfr_addr)
      `CSP_A_PCL: rd_mux = pc_cur[7:0];
      `CSP_A_TBLP: rd_mux = tblp_ff;
      `CSP_A_TABLE_HIGH_BYTE_LATCH: rd_mux = {1'b0, table_high_byte_latch_ff};
      `CSP_A_TABLE_POINTER_UPPER: rd_mux = {4'h0, table_pointer_upper_ff};
      `CSP_A_WATCHDOG_PRESCALE_SELECT: rd_mux = {5'h00, watchdog_prescale_select_ff};
      `CSP_A_STATUS: rd_mux = {2'h0, status_ff};
      `CSP_A_INTERRUPT_CONTROL_REG: begin
        rd_mux = {5'h00, timer_int_en_ff, ext_int_en_ff, master_interrupt_enable_ff};
      end
      `CSP_A_PORT_BASE: rd_mux = port_rd[7:0];
      `CSP_A_PORT_BASE + 8'h01: rd_mux = port_dir[7:0];
      `CSP_A_PORT_BASE + 8'h02: rd_mux = port_rd[15:8];
      `CSP_A_PORT_BASE + 8'h03: rd_mux = port_dir[15:8];
      `CSP_A_PORT_BASE + 8'h04: rd_mux = port_rd[23:16];
      `CSP_A_PORT_BASE + 8'h05: rd_mux = port_dir[23:16];
      default: rd_mux = 8'h00;
    endcase
  end

  // mask of sel low bits: divide ratio 2^sel, from 1 up to 128
  always @* begin
    wdt_lim = `CSP_WDT_DIV_MAX >> (3'h7 - watchdog_prescale_select_ff);
  end

  // ****************************************
  // program side registers
  // ****************************************
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      sfr_rdata_ff <= 8'h00;
      jump_ff <= 1'b0;
      jump_addr_ff <= 12'h000;
      dummy_cycle_ff <= 1'b0;
      tblp_ff <= 8'h00;
      table_pointer_upper_ff <= 4'h0;
      table_high_byte_latch_ff <= 7'h00;
      tab_dst_ff <= 8'h00;
      rom_req_ff <= 1'b0;
      rom_addr_ff <= 12'h000;
      tab_lo_wr_ff <= 1'b0;
      tab_lo_addr_ff <= 8'h00;
      tab_lo_data_ff <= 8'h00;
    end else if (clk_en) begin
      if (sfr_rd) begin
        sfr_rdata_ff <= rd_mux;
      end
      // the jump keeps the page, then one bubble cycle follows
      jump_ff <= sfr_wr && hit(sfr_addr, `CSP_A_PCL);
      if (sfr_wr && hit(sfr_addr, `CSP_A_PCL)) begin
        jump_addr_ff <= {pc_cur[11:8], sfr_wdata};
      end
      dummy_cycle_ff <= jump_ff;
      if (sfr_wr && hit(sfr_addr, `CSP_A_TBLP)) begin
        tblp_ff <= sfr_wdata;
      end
      if (sfr_wr && hit(sfr_addr, `CSP_A_TABLE_POINTER_UPPER)) begin
        table_pointer_upper_ff <= sfr_wdata[3:0];
      end
      rom_req_ff <= tab_rd;
      if (tab_rd) begin
        rom_addr_ff <= opt_table_pointer_upper_en ? {table_pointer_upper_ff, tblp_ff} : {pc_cur[11:8], tblp_ff};
        tab_dst_ff <= tab_dst;
      end
      // high latch is read-only to software, only a table read loads it
      tab_lo_wr_ff <= rom_valid;
      if (rom_valid) begin
        table_high_byte_latch_ff <= rom_data[14:8];
        tab_lo_data_ff <= rom_data[7:0];
        tab_lo_addr_ff <= tab_dst_ff;
      end
    end
  end

  // ****************************************
  // status, interrupt control, watchdog, power down
  // ****************************************
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      status_ff <= 6'h00;
      master_interrupt_enable_ff <= 1'b0;
      ext_int_en_ff <= 1'b0;
      timer_int_en_ff <= 1'b0;
      watchdog_prescale_select_ff <= 3'h7;
      wdt_cnt_ff <= 7'h00;
      wdt_tick_ff <= 1'b0;
      wdt_reset_req_ff <= 1'b0;
      clk_stop_ff <= 1'b0;
      wake_ff <= 1'b0;
      ext_int_req_ff <= 1'b0;
      timer_event_input_ff <= 1'b0;
      pc2_prev_ff <= 1'b1;
    end else if (clk_en) begin
      // a status write has priority over the flags of the same instruction
      if (st_wr) begin
        status_ff[`CSP_ST_C] <= sfr_wdata[`CSP_ST_C];
        status_ff[`CSP_ST_AC] <= sfr_wdata[`CSP_ST_AC];
        status_ff[`CSP_ST_Z] <= sfr_wdata[`CSP_ST_Z];
        status_ff[`CSP_ST_OV] <= sfr_wdata[`CSP_ST_OV];
      end else begin
        if (alu_upd_c) begin
          status_ff[`CSP_ST_C] <= f_c;
        end
        if (alu_upd_acov) begin
          status_ff[`CSP_ST_AC] <= f_ac;
          status_ff[`CSP_ST_OV] <= f_ov;
        end
        if (alu_upd_z) begin
          status_ff[`CSP_ST_Z] <= f_z;
        end
      end
      // only halt, watchdog clear and watchdog overflow touch these; set wins a tie
      if (halt_instr) begin
        status_ff[`CSP_ST_PDF] <= 1'b1;
      end else if (watchdog_clear_instr) begin
        status_ff[`CSP_ST_PDF] <= 1'b0;
      end
      if (wdt_overflow) begin
        status_ff[`CSP_ST_TO] <= 1'b1;
      end else if (watchdog_clear_instr || halt_instr) begin
        status_ff[`CSP_ST_TO] <= 1'b0;
      end
      if (sfr_wr && hit(sfr_addr, `CSP_A_INTERRUPT_CONTROL_REG)) begin
        ext_int_en_ff <= sfr_wdata[`CSP_IC_EEI];
        timer_int_en_ff <= sfr_wdata[`CSP_IC_ETI];
      end
      // return sets, entry clears; no status is stacked either way
      if (int_entry) begin
        master_interrupt_enable_ff <= 1'b0;
      end else if (return_from_interrupt) begin
        master_interrupt_enable_ff <= 1'b1;
      end else if (sfr_wr && hit(sfr_addr, `CSP_A_INTERRUPT_CONTROL_REG)) begin
        master_interrupt_enable_ff <= sfr_wdata[`CSP_IC_EMI];
      end
      if (sfr_wr && hit(sfr_addr, `CSP_A_WATCHDOG_PRESCALE_SELECT)) begin
        watchdog_prescale_select_ff <= sfr_wdata[2:0];
        wdt_cnt_ff <= 7'h00;
      end else if (wdt_src_tick) begin
        wdt_cnt_ff <= (wdt_cnt_ff >= wdt_lim) ? 7'h00 : wdt_cnt_ff + 7'h01;
      end
      wdt_tick_ff <= wdt_src_tick && (wdt_cnt_ff >= wdt_lim);
      wdt_reset_req_ff <= wdt_overflow;
      if (halt_instr) begin
        clk_stop_ff <= 1'b1;
      end else if (clk_stop_ff && (|port_wake)) begin
        clk_stop_ff <= 1'b0;
      end
      wake_ff <= clk_stop_ff && (|port_wake) && !halt_instr;
      // shared pins: timer clock on port a bit 2, interrupt on port c bit 2
      timer_event_input_ff <= pin_in[2];
      pc2_prev_ff <= pin_in[18];
      ext_int_req_ff <= ext_int_en_ff && pc2_prev_ff && !pin_in[18];
    end
  end

endmodule
`default_nettype wire

// file: tb/csp_pin_model.sv
/*
 * External circuitry on the 24 port pins: resolves each line's level.
 * Assumes ext_val changes only just after clk_sys rising edges.
 */
`default_nettype none

module csp_pin_model (
  input wire logic clk_sys,
  input wire logic [23:0] pin_out,
  input wire logic [23:0] pin_oe,
  input wire logic [23:0] pin_pullup,
  input wire logic [23:0] ext_val,
  input wire logic [23:0] ext_en,
  output logic [23:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [23:0] float_ff = 24'h000000;
  // a line nobody drives flips every cycle, so no stale level is read
  always @(posedge clk_sys) float_ff <= ~float_ff;
  // outside drive yields to the device's own driver
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
    | (~pin_oe & ~ext_en & (pin_pullup | float_ff));
endmodule
`default_nettype wire

// file: tb/csp_sfr_chk.sv
/*
 * Checker bound to csp_sfr: jump, table, power down, interrupt enable,
 * port latch and watchdog request timing, seen at the top ports only.
 * Assumes one clock, clk_sys, and the synchronous active-low rst_n.
 */
`default_nettype none
`include "csp_defs.vh"

module csp_sfr_chk (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  input wire logic [11:0] pc_cur,
  input wire logic jump_ff,
  input wire logic [11:0] jump_addr_ff,
  input wire logic dummy_cycle_ff,
  input wire logic tab_rd,
  input wire logic opt_table_pointer_upper_en,
  input wire logic rom_req_ff,
  input wire logic [11:0] rom_addr_ff,
  input wire logic rom_valid,
  input wire logic [14:0] rom_data,
  input wire logic tab_lo_wr_ff,
  input wire logic [7:0] tab_lo_data_ff,
  input wire logic halt_instr,
  input wire logic clk_stop_ff,
  input wire logic wake_ff,
  input wire logic int_entry,
  input wire logic return_from_interrupt,
  input wire logic master_interrupt_enable_ff,
  input wire logic wdt_overflow,
  input wire logic wdt_reset_req_ff,
  input wire logic [23:0] pin_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  // ****************************************
  // assertions
  // ****************************************
  sequence s_pcl_wr;
    clk_en && sfr_wr && sfr_addr == `CSP_A_PCL;
  endsequence
  sequence s_jump_dummy;
    jump_ff && jump_addr_ff == {$past(pc_cur[11:8]), $past(sfr_wdata)} ##1 dummy_cycle_ff;
  endsequence
  a_pcl_jump: assert property (s_pcl_wr |=> s_jump_dummy)
    else $error("pcl write gave no in-page jump and dummy cycle");
  a_tab_page: assert property (clk_en && tab_rd && !opt_table_pointer_upper_en |=>
    rom_req_ff && rom_addr_ff[11:8] == $past(pc_cur[11:8]))
    else $error("table read not in current page");
  a_tab_low: assert property (clk_en && rom_valid |=>
    tab_lo_wr_ff && tab_lo_data_ff == $past(rom_data[7:0]))
    else $error("table low byte not written");
  a_halt_stop: assert property (clk_en && halt_instr |=> clk_stop_ff)
    else $error("halt did not stop clock");
  a_wake_cause: assert property (wake_ff |-> $past(clk_stop_ff))
    else $error("wake outside power down");
  a_emi_entry: assert property (clk_en && int_entry |=> !master_interrupt_enable_ff)
    else $error("master enable kept on entry");
  a_emi_return: assert property (clk_en && return_from_interrupt && !int_entry
    |=> master_interrupt_enable_ff)
    else $error("master enable not set on return");
  a_out_hold: assert property ($changed(pin_out) |->
    $past(clk_en && sfr_wr && sfr_addr inside {8'h12, 8'h14, 8'h16}))
    else $error("output latch changed without port write");
  a_wdt_reset: assert property (clk_en && wdt_overflow |=> wdt_reset_req_ff)
    else $error("watchdog overflow gave no reset");
endmodule

bind csp_sfr csp_sfr_chk i_chk (.clk_sys, .rst_n, .clk_en, .sfr_addr, .sfr_wr, .sfr_wdata,
  .pc_cur, .jump_ff, .jump_addr_ff, .dummy_cycle_ff, .tab_rd, .opt_table_pointer_upper_en, .rom_req_ff,
  .rom_addr_ff, .rom_valid, .rom_data, .tab_lo_wr_ff, .tab_lo_data_ff, .halt_instr,
  .clk_stop_ff, .wake_ff, .int_entry, .return_from_interrupt, .master_interrupt_enable_ff,
  .wdt_overflow, .wdt_reset_req_ff, .pin_out);
`default_nettype wire

// file: tb/test_csp_sfr.sv
/*
 * Self-checking bench for csp_sfr: register reads and writes, flags,
 * power down, interrupt enables, table reads, watchdog divider, ports.
 * Assumes csp_pin_model on the pins and the bench acting as the core.
 */
`default_nettype none
`include "csp_defs.vh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin errors++; $display("ERROR %0t: got %h exp %h", $time, g, e); end end

module test_csp_sfr;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 0, rst_n = 0, clk_en = 1, sfr_wr = 0, sfr_rd = 0, tab_rd = 0, opt_table_pointer_upper_en = 0;
  logic rom_valid = 0, alu_upd_c = 0, alu_upd_acov = 0, alu_upd_z = 0, alu_rot_left = 0;
  logic alu_cin = 0, halt_instr = 0, watchdog_clear_instr = 0, int_entry = 0;
  logic return_from_interrupt = 0, wdt_src_tick = 0, wdt_overflow = 0;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, tab_dst = 8'h00, alu_op_a = 8'h00;
  logic [7:0] alu_op_b = 8'h00, alu_logic_res = 8'h00, pu_opt_a = 8'h81;
  logic [11:0] pc_cur = 12'hA55;
  logic [14:0] rom_data = 15'h0000;
  logic [1:0] alu_mode = 2'h0;
  logic [3:0] pu_grp_bc = 4'h5;
  logic [23:0] wake_mask = 24'h000000, ext_val = 24'h000000, ext_en = 24'hFFFFFF;
  logic [23:0] pin_in, pin_out, pin_oe, pin_pullup;
  logic [7:0] sfr_rdata_ff, tab_lo_addr_ff, tab_lo_data_ff;
  logic [11:0] jump_addr_ff, rom_addr_ff;
  logic jump_ff, dummy_cycle_ff, rom_req_ff, tab_lo_wr_ff, wdt_tick_ff, wdt_reset_req_ff;
  logic clk_stop_ff, wake_ff, master_interrupt_enable_ff, ext_int_en_ff, timer_int_en_ff;
  logic ext_int_req_ff, timer_event_input_ff;
  int errors = 0, tests_run = 0, ticks = 0, irqs = 0, i;
  // mode, a, b, carry in, logic result, update c/acov/z, expected status
  logic [37:0] ft [5] = '{{2'h0, 8'hFF, 8'h01, 1'h0, 8'h55, 3'h7, 8'h07},
    {2'h3, 8'h80, 8'h80, 1'h0, 8'h00, 3'h4, 8'h06},
    {2'h1, 8'h10, 8'h01, 1'h1, 8'h55, 3'h7, 8'h01},
    {2'h0, 8'h7F, 8'h01, 1'h0, 8'h00, 3'h7, 8'h0A},
    {2'h2, 8'h00, 8'h00, 1'h0, 8'h00, 3'h1, 8'h0E}};

  csp_sfr i_dut (.clk_sys, .rst_n, .clk_en, .sfr_addr, .sfr_wr, .sfr_wdata, .sfr_rd,
    .sfr_rdata_ff, .pc_cur, .jump_ff, .jump_addr_ff, .dummy_cycle_ff, .tab_rd, .tab_dst,
    .opt_table_pointer_upper_en, .rom_req_ff, .rom_addr_ff, .rom_valid, .rom_data, .tab_lo_wr_ff,
    .tab_lo_addr_ff, .tab_lo_data_ff, .alu_upd_c, .alu_upd_acov, .alu_upd_z, .alu_mode,
    .alu_rot_left, .alu_op_a, .alu_op_b, .alu_cin, .alu_logic_res, .halt_instr,
    .watchdog_clear_instr, .int_entry, .return_from_interrupt, .wdt_src_tick, .wdt_overflow,
    .wdt_tick_ff, .wdt_reset_req_ff, .clk_stop_ff, .wake_ff, .master_interrupt_enable_ff,
    .ext_int_en_ff, .timer_int_en_ff, .ext_int_req_ff, .timer_event_input_ff, .pin_in,
    .pin_out, .pin_oe, .pin_pullup, .pu_opt_a, .pu_grp_bc, .wake_mask);
  csp_pin_model i_pins (.clk_sys, .pin_out, .pin_oe, .pin_pullup, .ext_val, .ext_en, .pin_in);

  always #2 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    if (wdt_tick_ff === 1'b1) ticks++;
    if (ext_int_req_ff === 1'b1) irqs++;
  end

  // ****************************************
  // access tasks
  // ****************************************
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    {sfr_addr, sfr_wdata, sfr_wr} <= {a, d, 1'b1};
    @(posedge clk_sys);
    sfr_wr <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    {sfr_addr, sfr_rd} <= {a, 1'b1};
    @(posedge clk_sys);
    sfr_rd <= 1'b0;
    @(posedge clk_sys);
    #1 `CHK(sfr_rdata_ff, e)
  endtask
  task automatic tdone(input string s);
    $display("test %s done", s);
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ****************************************
  // tests
  // ****************************************
  initial begin
    #40000;
    errors++;
    $display("ERROR %0t: run did not finish", $time);
    wrap_up();
  end

  initial begin
    cyc(20);
    rst_n <= 1'b1;
    cyc(2);
    #1 `CHK(pin_oe, 24'h000000)
    `CHK(pin_out, 24'hFFFFFF)
    `CHK(pin_pullup, 24'h0F0F81)
    for (i = 0; i < 3; i++) rdc(8'h13 + 8'(2 * i), 8'hFF);
    rdc(`CSP_A_STATUS, 8'h00);
    wr(8'h03, 8'hAA);
    rdc(8'h03, 8'h00);
    tdone("reset");
    wr(`CSP_A_PORT_BASE, 8'h5A);
    wr(8'h13, 8'h0F);
    #1 `CHK(pin_out[7:0], 8'h5A)
    `CHK(pin_oe[7:0], 8'hF0)
    @(posedge clk_sys) ext_val <= 24'h000033;
    rdc(`CSP_A_PORT_BASE, 8'h53);
    @(posedge clk_sys) ext_val <= 24'h00003C;
    rdc(`CSP_A_PORT_BASE, 8'h5C);
    `CHK(pin_pullup[7:0], 8'h01)
    // a write while the clock enable is low must not reach the latch
    @(posedge clk_sys) clk_en <= 1'b0;
    wr(`CSP_A_PORT_BASE, 8'hC3);
    @(posedge clk_sys) clk_en <= 1'b1;
    #1 `CHK(pin_out[7:0], 8'h5A)
    for (i = 0; i < 2; i++) begin
      @(posedge clk_sys) ext_val[2] <= ~ext_val[2];
      cyc(2);
      #1 `CHK(timer_event_input_ff, ext_val[2])
    end
    tdone("ports");
    wr(`CSP_A_STATUS, 8'hFF);
    rdc(`CSP_A_STATUS, 8'h0F);
    for (i = 0; i < 5; i++) begin
      @(posedge clk_sys);
      {alu_mode, alu_op_a, alu_op_b, alu_cin, alu_logic_res, alu_upd_c, alu_upd_acov,
        alu_upd_z} <= ft[i][37:8];
      @(posedge clk_sys);
      {alu_upd_c, alu_upd_acov, alu_upd_z} <= 3'h0;
      rdc(`CSP_A_STATUS, ft[i][7:0]);
    end
    tdone("flags");
    @(posedge clk_sys) wdt_overflow <= 1'b1;
    @(posedge clk_sys) wdt_overflow <= 1'b0;
    rdc(`CSP_A_STATUS, 8'h2E);
    @(posedge clk_sys) {halt_instr, wake_mask} <= {1'b1, 24'h000001};
    @(posedge clk_sys) halt_instr <= 1'b0;
    #1 `CHK(clk_stop_ff, 1'b1)
    rdc(`CSP_A_STATUS, 8'h1E);
    wr(`CSP_A_STATUS, 8'h30);
    rdc(`CSP_A_STATUS, 8'h10);
    @(posedge clk_sys) ext_val[0] <= 1'b1;
    for (i = 0; i < 4 && wake_ff !== 1'b1; i++) begin
      @(posedge clk_sys);
      #1;
    end
    `CHK(wake_ff, 1'b1)
    cyc(2);
    #1 `CHK(clk_stop_ff, 1'b0)
    @(posedge clk_sys) watchdog_clear_instr <= 1'b1;
    @(posedge clk_sys) watchdog_clear_instr <= 1'b0;
    rdc(`CSP_A_STATUS, 8'h00);
    tdone("power");
    wr(`CSP_A_INTERRUPT_CONTROL_REG, 8'h07);
    rdc(`CSP_A_INTERRUPT_CONTROL_REG, 8'h07);
    `CHK({ext_int_en_ff, timer_int_en_ff}, 2'h3)
    @(posedge clk_sys) int_entry <= 1'b1;
    @(posedge clk_sys) int_entry <= 1'b0;
    #1 `CHK(master_interrupt_enable_ff, 1'b0)
    rdc(`CSP_A_STATUS, 8'h00);
    @(posedge clk_sys) return_from_interrupt <= 1'b1;
    @(posedge clk_sys) return_from_interrupt <= 1'b0;
    #1 `CHK(master_interrupt_enable_ff, 1'b1)
    for (i = 0; i < 2; i++) begin
      if (i == 1) wr(`CSP_A_INTERRUPT_CONTROL_REG, 8'h01);
      @(posedge clk_sys) ext_val[18] <= 1'b1;
      cyc(3);
      @(posedge clk_sys) ext_val[18] <= 1'b0;
      cyc(4);
      `CHK(irqs, 1)
    end
    tdone("interrupt");
    wr(`CSP_A_TBLP, 8'h34);
    wr(`CSP_A_TABLE_POINTER_UPPER, 8'h05);
    for (i = 0; i < 2; i++) begin
      @(posedge clk_sys) {opt_table_pointer_upper_en, tab_dst, tab_rd} <= {i == 0, 8'h40, 1'b1};
      @(posedge clk_sys) tab_rd <= 1'b0;
      #1 `CHK(rom_addr_ff, (i == 0) ? 12'h534 : 12'hA34)
      @(posedge clk_sys) {rom_valid, rom_data} <= {1'b1, 15'h5ABC};
      @(posedge clk_sys) rom_valid <= 1'b0;
      #1 `CHK({tab_lo_addr_ff, tab_lo_data_ff}, 16'h40BC)
      wr(`CSP_A_TABLE_HIGH_BYTE_LATCH, 8'h00);
      rdc(`CSP_A_TABLE_HIGH_BYTE_LATCH, 8'h5A);
    end
    tdone("table");
    for (i = 0; i < 3; i++) begin
      wr(`CSP_A_WATCHDOG_PRESCALE_SELECT, 8'(i));
      ticks = 0;
      repeat (4) begin
        @(posedge clk_sys) wdt_src_tick <= 1'b1;
        @(posedge clk_sys) wdt_src_tick <= 1'b0;
      end
      cyc(2);
      `CHK(ticks, 4 >> i)
    end
    wr(`CSP_A_WATCHDOG_PRESCALE_SELECT, 8'hFF);
    rdc(`CSP_A_WATCHDOG_PRESCALE_SELECT, 8'h07);
    tdone("watchdog");
    wr(`CSP_A_PCL, 8'h3C);
    #1 `CHK({jump_ff, jump_addr_ff}, 13'h1A3C)
    @(posedge clk_sys);
    #1 `CHK(dummy_cycle_ff, 1'b1)
    tdone("jump");
    wrap_up();
  end
endmodule
`default_nettype wire
